// ---- rtl/flash_guard_host.sv ----
// host controller driving a parallel flash's bus and protection pins
// assumes one AHB-Lite master, 32-bit words, and that the flash pins
// see the bus levels this block drives; supply_ok comes from a monitor
//
// What this block does
// - lock by three-cycle enter then protect, reset high or high voltage
// - host refuses reads, writes and programs off the first sector in secured mode
// - write needs chip select and write strobe low, output enable high
// - program only after the required unlock cycles
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module flash_guard_host #(
  parameter int STROBE_CYC  = flash_guard_pkg::STROBE_CYC_DEF,
  parameter int SETUP_CYC   = flash_guard_pkg::SETUP_CYC_DEF,
  parameter int RST_CYC     = flash_guard_pkg::RST_CYC_DEF,
  parameter int SEC_ADDR_W  = 12,      // word address bits of first sector
  parameter logic [21:0] UNLOCK_A1 = 22'h000555,
  parameter logic [21:0] UNLOCK_A2 = 22'h0002aa,
  parameter logic [15:0] UNLOCK_D1 = 16'h00aa,
  parameter logic [15:0] UNLOCK_D2 = 16'h0055,
  parameter logic [15:0] PROG_CODE = 16'h00a0,
  parameter logic [15:0] ENTER_CODE = 16'h0088,
  parameter logic [15:0] EXIT_CODE  = 16'h0090
) (
  // clock, reset, enable
  input  wire logic                               hclk,
  input  wire logic                               hresetn,
  input  wire logic                               clk_en,
  // ahb-lite slave
  input  wire logic                               hsel,
  input  wire logic [31:0]                        haddr,
  input  wire logic [1:0]                         htrans,
  input  wire logic                               hwrite,
  input  wire logic [2:0]                         hsize,
  input  wire logic [31:0]                        hwdata,
  input  wire logic                               hready,
  output logic      [31:0]                        hrdata,
  output logic                                    hreadyout,
  output logic                                    hresp,
  // flash bus
  output logic      [flash_guard_pkg::ADDR_W-1:0] flash_addr,
  output logic                                    flash_ce_n,
  output logic                                    flash_we_n,
  output logic                                    flash_oe_n,
  output logic      [flash_guard_pkg::DATA_W-1:0] dq_o,
  output logic                                    dq_oe,
  input  wire logic [flash_guard_pkg::DATA_W-1:0] dq_i,
  // protection pins
  output logic                                    flash_rst_n,
  output logic                                    hv_req,
  output logic                                    guard_o,
  output logic                                    guard_oe,
  input  wire logic                               supply_ok
);
  import flash_guard_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]        bus_ofs_r;
  logic              bus_wr_r;
  logic              bus_wait_r;
  logic [1:0]        ctrl_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;
  logic              rvalid_r;
  logic              refused_r;
  logic              secured_r;
  logic [DATA_W-1:0] dq_s1_r, dq_s2_r;
  logic [1:0]        sup_sync_r;
  state_t            state_r;
  op_t               op_r;
  logic [1:0]        step_r;
  logic [CNT_W-1:0]  cnt_r;
  logic              cmd_wr;
  logic              cmd_ok;
  logic              last_step;
  logic [ADDR_W+DATA_W-1:0] cyc;

  // lengths cast once so the counters compare at their own width
  localparam logic [CNT_W-1:0] SETUP_N  = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] STROBE_N = CNT_W'((STROBE_CYC > GLITCH_CYC)
                                          ? STROBE_CYC : GLITCH_CYC + 1);
  localparam logic [CNT_W-1:0] READ_N   = CNT_W'(STROBE_CYC + SYNC_CYC);
  localparam logic [CNT_W-1:0] RST_N    = CNT_W'(RST_CYC);

  // ----------------------------------------------------------------
  // sequence table: address and data of each bus cycle
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W+DATA_W-1:0] seq_cycle(
    input op_t op, input logic [1:0] step,
    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [ADDR_W+DATA_W-1:0] r;
    r = {a, d};
    if (op == OP_PROG || op == OP_ENTER || op == OP_EXIT) begin
      case (step)
        2'd0:    r = {UNLOCK_A1, UNLOCK_D1};
        2'd1:    r = {UNLOCK_A2, UNLOCK_D2};
        2'd2:    r = {UNLOCK_A1, (op == OP_PROG) ? PROG_CODE :
                      (op == OP_ENTER) ? ENTER_CODE : EXIT_CODE};
        default: r = (op == OP_EXIT) ? {ADDR_W+DATA_W{1'b0}} : {a, d};
      endcase
    end
    return r;
  endfunction

  // last step of each operation; enter is the three-cycle form
  function automatic logic [1:0] seq_last(input op_t op);
    case (op)
      OP_PROG, OP_EXIT: return 2'd3;
      OP_ENTER:         return 2'd2;
      default:          return 2'd0;
    endcase
  endfunction

  assign cyc       = seq_cycle(op_r, step_r, addr_r, wdata_r);
  assign last_step = (step_r == seq_last(op_r));
  assign cmd_wr    = bus_wait_r && bus_wr_r && bus_ofs_r == OFS_CMD;
  // refuse while busy, with supply low, or off the first sector in
  // secured mode, since the rest of the array is not reachable then
  assign cmd_ok = state_r == S_IDLE && sup_sync_r[1] &&
                  !(secured_r && hwdata[2:0] inside {OP_READ, OP_WRITE,
                    OP_PROG} && (addr_r >> SEC_ADDR_W) != '0) &&
                  hwdata[2:0] inside {OP_READ, OP_WRITE, OP_PROG,
                    OP_ENTER, OP_EXIT, OP_HWRST};

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dq_s1_r    <= '0;
      dq_s2_r    <= '0;
      sup_sync_r <= 2'h0;
    end else if (clk_en) begin
      dq_s1_r    <= dq_i;
      dq_s2_r    <= dq_s1_r;
      sup_sync_r <= {sup_sync_r[0], supply_ok};
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave: one wait state, answer always okay
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_ofs_r  <= 8'h00;
      bus_wr_r   <= 1'b0;
      bus_wait_r <= 1'b0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;  // okay only, held from reset
      hrdata     <= 32'h0000_0000;
    end else if (clk_en) begin
      if (bus_wait_r) begin
        bus_wait_r <= 1'b0;
        hreadyout  <= 1'b1;
        if (!bus_wr_r) begin
          case (bus_ofs_r)
            OFS_CTRL:   hrdata <= {30'h0, ctrl_r};
            OFS_ADDR:   hrdata <= {10'h0, addr_r};
            OFS_WDATA:  hrdata <= {16'h0, wdata_r};
            OFS_CMD:    hrdata <= {29'h0, op_r};
            OFS_STATUS: hrdata <= {27'h0, rvalid_r, sup_sync_r[1],
                                   refused_r, secured_r,
                                   state_r != S_IDLE};
            OFS_RDATA:  hrdata <= {16'h0, rdata_r};
            default:    hrdata <= 32'h0000_0000;
          endcase
        end
      end else if (hsel && htrans[1] && hready) begin
        bus_ofs_r  <= {haddr[7:2], 2'b00};
        bus_wr_r   <= hwrite;
        bus_wait_r <= 1'b1;
        hreadyout  <= 1'b0;
      end
    end
  end
  // software registers; set of refused wins over its clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r    <= CTRL_RST;
      addr_r    <= '0;
      wdata_r   <= '0;
      refused_r <= 1'b0;
    end else if (clk_en) begin
      if (bus_wait_r && bus_wr_r) begin
        case (bus_ofs_r)
          OFS_CTRL:  ctrl_r  <= hwdata[1:0];
          OFS_ADDR:  addr_r  <= hwdata[ADDR_W-1:0];
          OFS_WDATA: wdata_r <= hwdata[DATA_W-1:0];
          default:   ;
        endcase
      end
      if (cmd_wr && !cmd_ok)
        refused_r <= 1'b1;
      else if (bus_wait_r && bus_wr_r && bus_ofs_r == OFS_STATUS &&
               hwdata[ST_REFUSED])
        refused_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // protection pins
  // ----------------------------------------------------------------
  // guard released rather than driven high: the pin's pull-up gives
  // the inactive level, so a board strap may still hold it low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      guard_o  <= 1'b0;
      guard_oe <= 1'b0;
      hv_req   <= 1'b0;
    end else if (clk_en) begin
      guard_oe <= ctrl_r[CTRL_GUARD];
      hv_req   <= ctrl_r[CTRL_HV];
    end
  end

  // ----------------------------------------------------------------
  // flash bus sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r     <= S_IDLE;
      op_r        <= OP_NONE;
      step_r      <= 2'd0;
      cnt_r       <= '0;
      flash_addr  <= '0;
      flash_ce_n  <= 1'b1;
      flash_we_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      dq_o        <= '0;
      dq_oe       <= 1'b0;
      flash_rst_n <= 1'b1;
    end else if (clk_en) begin
      case (state_r)
        S_IDLE: begin
          if (cmd_wr && cmd_ok) begin
            op_r   <= op_t'(hwdata[2:0]);
            step_r <= 2'd0;
            cnt_r  <= '0;
            if (op_t'(hwdata[2:0]) == OP_HWRST) begin
              flash_rst_n <= 1'b0;
              state_r     <= S_RESET;
            end else begin
              state_r <= S_SETUP;
            end
          end
        end
        S_SETUP: begin
          // address and data settle with strobes high for SETUP_CYC-1 cycles; none when SETUP_CYC is 1
          flash_addr <= cyc[ADDR_W+DATA_W-1:DATA_W];
          dq_o       <= cyc[DATA_W-1:0];
          dq_oe      <= op_r != OP_READ;
          flash_ce_n <= 1'b0;
          cnt_r      <= cnt_r + 1'b1;
          if (cnt_r + 1'b1 >= SETUP_N) begin
            cnt_r   <= '0;
            state_r <= S_STROBE;
            // output enable stays high across a write
            if (op_r == OP_READ)
              flash_oe_n <= 1'b0;
            else
              flash_we_n <= 1'b0;
          end
        end
        S_STROBE: begin
          // strobe outlasts the glitch filter
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r + 1'b1 >= ((op_r == OP_READ) ? READ_N : STROBE_N)) begin
            cnt_r      <= '0;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            state_r    <= S_HOLD;
          end
        end
        S_HOLD: begin
          // chip select rises after the strobe, data held one cycle
          flash_ce_n <= 1'b1;
          dq_oe      <= 1'b0;
          // a supply drop ends the sequence instead of starting a cycle
          if (last_step || !sup_sync_r[1]) begin
            state_r <= S_IDLE;
          end else begin
            step_r  <= step_r + 2'd1;
            state_r <= S_SETUP;
          end
        end
        S_RESET: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r + 1'b1 >= RST_N) begin
            flash_rst_n <= 1'b1;
            state_r     <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // read capture and the host's view of the secured mapping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r   <= '0;
      rvalid_r  <= 1'b0;
      secured_r <= 1'b0;
    end else if (clk_en) begin
      if (state_r == S_STROBE && op_r == OP_READ &&
          cnt_r + 1'b1 >= READ_N) begin
        rdata_r  <= dq_s2_r;
        rvalid_r <= 1'b1;
      end else if (cmd_wr && cmd_ok && hwdata[2:0] == OP_READ) begin
        rvalid_r <= 1'b0;
      end
      if (state_r == S_HOLD && last_step && op_r == OP_ENTER)
        secured_r <= 1'b1;
      else if (state_r == S_HOLD && last_step && op_r == OP_EXIT)
        secured_r <= 1'b0;
      else if (state_r == S_RESET || !sup_sync_r[1])
        secured_r <= 1'b0;
    end
  end
endmodule

// ---- rtl/flash_guard_pkg.sv ----
// constants shared by the flash protection controller
// assumes a 16-bit parallel flash on word addresses and a 50 MHz clock
package flash_guard_pkg;
  // ----------------------------------------------------------------
  // clock and pin timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 50;
  localparam int GLITCH_NS      = 5;   // device ignores shorter pulses
  localparam int GLITCH_CYC     = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC_DEF = 4;   // write strobe length; read adds SYNC_CYC
  localparam int SETUP_CYC_DEF  = 1;   // address setup before strobe
  localparam int SYNC_CYC       = 2;   // pin synchroniser depth
  localparam int RST_CYC_DEF    = 32;  // hardware reset pulse length
  localparam int CNT_W          = 8;

  // ----------------------------------------------------------------
  // register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_CMD    = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RDATA  = 8'h14;

  // control bits
  localparam int CTRL_GUARD = 0;  // pull boot guard to logic_low_level
  localparam int CTRL_HV    = 1;  // ask for high_voltage_level on reset
  // status bits
  localparam int ST_BUSY    = 0;
  localparam int ST_SECURED = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_SUPPLY  = 3;
  localparam int ST_RVALID  = 4;

  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_READ  = 3'h1,
    OP_WRITE = 3'h2,  // one raw bus write cycle
    OP_PROG  = 3'h3,  // unlock cycles then the data word
    OP_ENTER = 3'h4,  // enter secured sector mapping
    OP_EXIT  = 3'h5,  // leave secured sector mapping
    OP_HWRST = 3'h6   // pulse the hardware reset pin
  } op_t;

  // gray coded along setup, strobe, hold
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_SETUP  = 3'b001,
    S_STROBE = 3'b011,
    S_HOLD   = 3'b010,
    S_RESET  = 3'b110
  } state_t;

  // reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
endpackage

// ---- verif/flash_guard_sva.sv ----
// checker for the flash protection host controller
// assumes only the top-level ports; bound in at the foot of this file
`timescale 1ns/10ps
module flash_guard_chk #(
  parameter int STROBE_CYC = 4,
  parameter int RST_CYC    = 32
) (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // flash bus and protection pins
  input wire logic [21:0] flash_addr,
  input wire logic        flash_ce_n,
  input wire logic        flash_we_n,
  input wire logic        flash_oe_n,
  input wire logic [15:0] dq_o,
  input wire logic        dq_oe,
  input wire logic        flash_rst_n,
  input wire logic        guard_o,
  input wire logic        guard_oe,
  input wire logic        supply_ok
);
  // ----------------------------------------------------------------
  // low-time counters, so write strobe and reset pulse lengths are checked exactly
  // ----------------------------------------------------------------
  logic [7:0] we_cnt_r;
  logic [7:0] rst_cnt_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      we_cnt_r  <= 8'h00;
      rst_cnt_r <= 8'h00;
    end else begin
      we_cnt_r  <= flash_we_n ? 8'h00 : we_cnt_r + 8'h01;
      rst_cnt_r <= flash_rst_n ? 8'h00 : rst_cnt_r + 8'h01;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_wr_sel;
    !flash_we_n |-> !flash_ce_n && flash_oe_n;
  endproperty
  a_wr_sel: assert property (p_wr_sel)
    else $error("write strobe without select or with output enable");
  property p_rd_sel;
    !flash_oe_n |-> !flash_ce_n && flash_we_n && !dq_oe;
  endproperty
  a_rd_sel: assert property (p_rd_sel)
    else $error("read strobe overlaps write or data drive");
  property p_wr_len;
    $rose(flash_we_n) |-> we_cnt_r == STROBE_CYC;
  endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("write strobe length wrong");
  property p_dq_hold;
    !flash_we_n && !$past(flash_we_n) |->
      $stable(dq_o) && $stable(flash_addr) && dq_oe;
  endproperty
  a_dq_hold: assert property (p_dq_hold)
    else $error("data or address moved under write strobe");
  property p_ce_hold;
    !flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("address moved while selected");
  property p_we_first;
    $rose(flash_we_n) |-> !flash_ce_n;
  endproperty
  a_we_first: assert property (p_we_first)
    else $error("select released before write strobe");
  property p_guard;
    guard_oe |-> !guard_o;
  endproperty
  a_guard: assert property (p_guard)
    else $error("boot guard driven high");
  property p_rst_len;
    $rose(flash_rst_n) |-> rst_cnt_r == RST_CYC;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("reset pulse length wrong");
  // two sync stages plus one command already in flight
  property p_supply;
    !supply_ok [*4] ##0 flash_ce_n |=> flash_ce_n;
  endproperty
  a_supply: assert property (p_supply)
    else $error("bus cycle started on low supply");
  c_write: cover property ($rose(flash_we_n));
  c_read:  cover property ($rose(flash_oe_n));
  c_reset: cover property ($rose(flash_rst_n));
  c_guard: cover property ($rose(guard_oe));
endmodule
bind flash_guard_host flash_guard_chk #(
  .STROBE_CYC(STROBE_CYC), .RST_CYC(RST_CYC)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .flash_addr(flash_addr),
  .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
  .flash_oe_n(flash_oe_n), .dq_o(dq_o), .dq_oe(dq_oe),
  .flash_rst_n(flash_rst_n), .guard_o(guard_o), .guard_oe(guard_oe),
  .supply_ok(supply_ok));

// ---- verif/flash_dev_model.sv ----
// behavioural model of the protected parallel flash
// assumes the bench resolves the boot guard pin, pull-up when released
`timescale 1ns/10ps
module flash_dev_model #(
  parameter logic [15:0] SERIAL0  = 16'h5a3c, // arbitrary serial word
  parameter bit          LOCKED   = 1'b1,
  parameter logic [4:0]  PROT_GRP = 5'h01
) (
  // flash bus
  input  wire logic [21:0] flash_addr,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic [15:0] dq_o,
  output wire logic [15:0] dq_i,
  // protection pins
  input  wire logic        flash_rst_n,
  input  wire logic        hv_req,
  input  wire logic        boot_guard,
  input  wire logic        supply_ok
);
  // ----------------------------------------------------------------
  // array, secured sector and command state
  // ----------------------------------------------------------------
  logic [15:0] mem [int];
  logic [15:0] sec_mem [128];
  logic [1:0]  step;
  logic        prog;
  logic        secured;
  logic [15:0] last_q;
  realtime     t_fall;
  function automatic logic [15:0] rd_word(input logic [21:0] a);
    if (secured && a < 22'h001000)
      return (LOCKED && a[6:0] > 7'd7) ? 16'hffff : sec_mem[a[6:0]];
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  // boot guard wins over everything; group state yields to high voltage
  function automatic bit may_write(input logic [21:0] a);
    if (!boot_guard && a < 22'h001000) return 1'b0;
    if (a[21:17] == PROT_GRP && !hv_req) return 1'b0;
    return 1'b1;
  endfunction
  initial begin
    step = 2'd0;
    prog = 1'b0;
    secured = 1'b0;
    last_q = 16'h0000;
    t_fall = 0.0;
    foreach (sec_mem[i]) sec_mem[i] = (i == 0) ? SERIAL0 : 16'hffff;
  end
  // released bus shows the inverse of the last word, not a held value
  assign dq_i = (!flash_ce_n && !flash_oe_n) ? rd_word(flash_addr) : ~last_q;
  always @(posedge flash_oe_n) last_q = rd_word(flash_addr);
  always @(negedge flash_we_n) t_fall = $realtime;
  // commands latch on the rising write strobe
  always @(posedge flash_we_n or negedge flash_rst_n or negedge supply_ok)
  begin
    if (!flash_rst_n || !supply_ok) begin
      step = 2'd0;
      prog = 1'b0;
      secured = 1'b0;
    end else if (!flash_ce_n && flash_oe_n && $realtime - t_fall >= 5.0)
    begin
      if (prog) begin
        if (secured && flash_addr < 22'h001000) begin
          if (!LOCKED) sec_mem[flash_addr[6:0]] = dq_o;
        end else if (may_write(flash_addr)) mem[flash_addr] = dq_o;
        prog = 1'b0;
        step = 2'd0;
      end else if (step == 2'd0)
        step = (flash_addr == 22'h555 && dq_o == 16'haa) ? 2'd1 : 2'd0;
      else if (step == 2'd1)
        step = (flash_addr == 22'h2aa && dq_o == 16'h55) ? 2'd2 : 2'd0;
      else begin
        prog = (dq_o == 16'ha0);
        if (dq_o == 16'h88) secured = 1'b1;
        if (dq_o == 16'h90) secured = 1'b0;
        step = 2'd0;
      end
    end
  end
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench: ahb-lite register tasks against the flash model
// assumes the checker is bound in by its own file
`timescale 1ns/10ps
module tb_top;
  import flash_guard_pkg::*;
  // ----------------------------------------------------------------
  // signals, design and partner
  // ----------------------------------------------------------------
  logic        hclk, hresetn, clk_en, hsel, hwrite, supply_ok, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, ce_n, we_n, oe_n, dq_oe, rst_n, hv_req;
  logic        guard_o, guard_oe;
  logic [21:0] faddr;
  logic [15:0] dq_o, dq_i;
  int          num_errors, comparisons;
  wire         boot_guard = guard_oe ? guard_o : 1'b1; // pull-up
  flash_guard_host DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .flash_addr(faddr),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_i(dq_i), .flash_rst_n(rst_n), .hv_req(hv_req),
    .guard_o(guard_o), .guard_oe(guard_oe), .supply_ok(supply_ok));
  flash_dev_model u_flash (.flash_addr(faddr), .flash_ce_n(ce_n),
    .flash_we_n(we_n), .flash_oe_n(oe_n), .dq_o(dq_o), .dq_i(dq_i),
    .flash_rst_n(rst_n), .hv_req(hv_req), .boot_guard(boot_guard),
    .supply_ok(supply_ok));
  task automatic check(input logic [31:0] got, exp, input string s);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  // one single transfer; entered just after a rising edge
  task automatic ahb(input bit w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cmd(input op_t op, input logic [21:0] a, input logic [15:0] d);
    ahb(1'b1, OFS_ADDR, {10'h0, a});
    ahb(1'b1, OFS_WDATA, {16'h0, d});
    ahb(1'b1, OFS_CMD, {29'h0, op});
    for (int i = 0; i < 300; i++) begin
      ahb(1'b0, OFS_STATUS, 32'h0);
      if (rd[ST_BUSY] === 1'b0) break;
    end
    if (rd[ST_BUSY] !== 1'b0) begin
      num_errors++;
      $display("BAD t=%0t busy never cleared", $time);
    end
  endtask
  task automatic rdf(input logic [21:0] a, input logic [15:0] e, string s);
    cmd(OP_READ, a, 16'h0);
    ahb(1'b0, OFS_RDATA, 32'h0);
    check(rd, {16'h0, e}, s);
  endtask
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // hang guard, far beyond the several hundred cycles the tests take
  initial begin
    #1000000;
    num_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    {clk_en, supply_ok, hsize, num_errors, comparisons} = {2'b11, 3'h2, 64'h0};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({guard_oe, hv_req, rst_n}, 32'h1, "reset pins");
    ahb(1'b0, OFS_CTRL, 32'h0);
    check(rd, 32'h0, "ctrl reset");
    ahb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0, "unmapped read");
    $display("test reset done");
    cmd(OP_PROG, 22'h000010, 16'h1234);
    rdf(22'h000010, 16'h1234, "boot prog");
    check(hresp, 32'h0, "okay response");
    ahb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h18, "status after read");
    ahb(1'b0, OFS_CMD, 32'h0);
    check(rd, 32'h1, "last op");
    ahb(1'b0, OFS_ADDR, 32'h0);
    check(rd, 32'h10, "addr readback");
    ahb(1'b1, OFS_CTRL, 32'h1);
    cmd(OP_PROG, 22'h000020, 16'h5555);
    rdf(22'h000020, 16'hffff, "guarded boot");
    cmd(OP_PROG, 22'h001020, 16'h0f0f);
    rdf(22'h001020, 16'h0f0f, "guard spares rest");
    $display("test boot guard done");
    ahb(1'b1, OFS_CTRL, 32'h0);
    cmd(OP_PROG, 22'h020000, 16'h1111);
    rdf(22'h020000, 16'hffff, "protected group");
    ahb(1'b1, OFS_CTRL, 32'h2);
    cmd(OP_PROG, 22'h03fff0, 16'h2222);
    rdf(22'h03fff0, 16'h2222, "temp unprotect");
    ahb(1'b1, OFS_CTRL, 32'h3);
    cmd(OP_PROG, 22'h000030, 16'h3333);
    rdf(22'h000030, 16'hffff, "guard beats hv");
    ahb(1'b1, OFS_CTRL, 32'h0);
    cmd(OP_PROG, 22'h020010, 16'h4444);
    rdf(22'h020010, 16'hffff, "reprotected");
    cmd(OP_WRITE, 22'h000555, 16'h00a0);
    cmd(OP_WRITE, 22'h000040, 16'h7777);
    rdf(22'h000040, 16'hffff, "no unlock");
    $display("test group protection done");
    cmd(OP_ENTER, 22'h0, 16'h0);
    ahb(1'b0, OFS_STATUS, 32'h0);
    check(rd & 32'h2, 32'h2, "secured flag");
    rdf(22'h000000, 16'h5a3c, "serial word");
    rdf(22'h000008, 16'hffff, "unavailable word");
    cmd(OP_PROG, 22'h000003, 16'h0000);
    rdf(22'h000003, 16'hffff, "locked sector");
    cmd(OP_READ, 22'h001000, 16'h0);
    ahb(1'b0, OFS_STATUS, 32'h0);
    check(rd & 32'h4, 32'h4, "outside refused");
    ahb(1'b1, OFS_STATUS, 32'h4);
    cmd(OP_EXIT, 22'h0, 16'h0);
    rdf(22'h000010, 16'h1234, "exit maps array");
    cmd(OP_ENTER, 22'h0, 16'h0);
    cmd(OP_HWRST, 22'h0, 16'h0);
    ahb(1'b0, OFS_STATUS, 32'h0);
    check(rd & 32'h2, 32'h0, "reset clears secured");
    rdf(22'h000010, 16'h1234, "reset maps array");
    $display("test secured sector done");
    supply_ok <= 1'b0;
    repeat (4) @(posedge hclk);
    cmd(OP_PROG, 22'h001030, 16'h9999);
    ahb(1'b0, OFS_STATUS, 32'h0);
    check(rd & 32'hc, 32'h4, "low supply refused");
    supply_ok <= 1'b1;
    repeat (4) @(posedge hclk);
    rdf(22'h001030, 16'hffff, "nothing written");
    $display("test supply done");
    finish_test();
  end
endmodule
